/* hw/bsw_pkg.sv */
package bsw_pkg;

  // Clock and oscillator timebase
  localparam int unsigned CLK_PERIOD_NS   = 20;
  localparam int unsigned T_OSC_NS        = 12320;
  localparam int unsigned TICK_CYCLES_DEF =
    (T_OSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Watchdog times in ns, converted to oscillator ticks
  localparam int unsigned T_CLOSE_NS     = 12100000;
  localparam int unsigned T_OPEN_NS      = 9610000;
  localparam int unsigned T_RES_NS       = 68000000;
  localparam int unsigned T_LEAD_NS      = 68000000;
  localparam int unsigned T_SHORT_RES_NS = 2000000;
  localparam int unsigned CLOSE_TICKS_DEF = T_CLOSE_NS / T_OSC_NS;
  localparam int unsigned OPEN_TICKS_DEF  = T_OPEN_NS / T_OSC_NS;
  localparam int unsigned RES_TICKS_DEF   =
    (T_RES_NS + T_OSC_NS - 1) / T_OSC_NS;
  localparam int unsigned LEAD_TICKS_DEF  = T_LEAD_NS / T_OSC_NS;
  localparam int unsigned SHORT_RES_TICKS_DEF =
    (T_SHORT_RES_NS + T_OSC_NS - 1) / T_OSC_NS;

  // Short debounce, least time
  localparam int unsigned T_SC_NS   = 10000;
  localparam int unsigned SC_CYCLES =
    (T_SC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Default non-overlap time (typical RC network)
  localparam int unsigned T_DEAD_NS = 1353;
  localparam logic [7:0]  DEAD_CYCLES_RST =
    8'((T_DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Widths
  localparam int unsigned TICK_W = 13;
  localparam int unsigned DIV_W  = 10;
  localparam int unsigned SC_W   = 9;
  localparam int unsigned SYNC_W = 18;

  // Register byte offsets
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_RSTCNT = 4'h8;

  // Control field positions
  localparam int unsigned CTRL_SLEEP_BIT = 0;
  localparam int unsigned CTRL_DEAD_LSB  = 8;

  // Synchronised input positions
  localparam int unsigned IN_KICK    = 0;
  localparam int unsigned IN_DIR     = 1;
  localparam int unsigned IN_PWM     = 2;
  localparam int unsigned IN_TX      = 3;
  localparam int unsigned IN_LOW     = 4;
  localparam int unsigned IN_NOTHIGH = 5;
  localparam int unsigned IN_PUMP    = 6;
  localparam int unsigned IN_WARN    = 7;
  localparam int unsigned IN_CUT     = 8;
  localparam int unsigned IN_COOL    = 9;
  localparam int unsigned IN_BUSHOT  = 10;
  localparam int unsigned IN_VCCPG   = 11;
  localparam int unsigned IN_INTPG   = 12;
  localparam int unsigned IN_LEVEL   = 13;
  localparam int unsigned IN_SHORT   = 14;

  // Watchdog states
  typedef enum logic [3:0] {
    WD_RESET  = 4'h1,
    WD_LEAD   = 4'h2,
    WD_CLOSED = 4'h4,
    WD_OPEN   = 4'h8
  } bsw_wd_state_type;

  // Four bridge gates, bit order high_a, low_a, high_b, low_b
  typedef struct packed {
    logic high_a;
    logic low_a;
    logic high_b;
    logic low_b;
  } bsw_gate_type;

  // Three diagnostic pins
  typedef struct packed {
    logic short_fault_out;
    logic supply_fault_out;
    logic heat_warning_out;
  } bsw_diag_type;

endpackage

/* hw/bsw_core.sv */
// The Avalon-MM register port and the address map were decided locally.
`timescale 1ns/1ns
// Function
// - Internal power-good low holds all logic reset
// - Battery tap on with supply or watchdog reset
// - Battery alarm turns gates off, flags supply fault
// - First heat threshold raises heat warning output
// - Heat cutoff kills regulator, gates, bus, reset
// - Leave shutdown only after cooling below recovery
// - Bus overheat disables only bus low-side driver
// - Level select is a static strap
// - Host reset held while supply power-good low
// - Watchdog stopped, no resets, during sleep
// - Power-on: hold host reset, then release
// - After release, lead time for first kick
// - No kick in lead: reset, then lead again
// - Period is closed window then open window
// - Open-window kick restarts closed window
// - Failed kick gives short reset, then restart
// - Transmit input forwarded to bus driver
// - Block transmit on shutdown or bus overheat
// - Bridge enable low forces all gates off
// - Direction and PWM pick gate pattern
// - Bridge enable needs kick, supply, pump, cool
// - Debounced short switches affected gate off
// - Non-overlap delay before opposite gate turns on
// - Diagnostic outputs follow fault conditions
// - PWM transition clears latched short faults
// - Non-overlap timing starts on PWM/direction change
module bsw_core
  import bsw_pkg::*;
#(
  parameter int unsigned TICK_CYCLES     = TICK_CYCLES_DEF,
  parameter int unsigned CLOSE_TICKS     = CLOSE_TICKS_DEF,
  parameter int unsigned OPEN_TICKS      = OPEN_TICKS_DEF,
  parameter int unsigned RES_TICKS       = RES_TICKS_DEF,
  parameter int unsigned LEAD_TICKS      = LEAD_TICKS_DEF,
  parameter int unsigned SHORT_RES_TICKS = SHORT_RES_TICKS_DEF
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         watchdog_kick_in,
  input  wire logic         dir_in,
  input  wire logic         pwm_in,
  input  wire logic         tx_in,
  input  wire logic         supply_too_low,
  input  wire logic         supply_not_high,
  input  wire logic         pump_good,
  input  wire logic         heat_warning,
  input  wire logic         heat_cutoff,
  input  wire logic         heat_recovered,
  input  wire logic         bus_overheat,
  input  wire logic         vcc_power_good,
  input  wire logic         int_power_good,
  input  wire logic         supply_level_select,
  input  wire logic [3:0]   short_detect,
  input  wire logic [3:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  input  wire logic [3:0]   avs_byteenable,
  output logic [31:0]       avs_readdata,
  output logic              avs_waitrequest,
  output logic              host_reset_n,
  output logic              regulator_en,
  output logic              battery_tap_out,
  output logic              level_3v3_out,
  output bsw_gate_type      gates,
  output bsw_diag_type      diag,
  output logic              bus_tx_out,
  output logic              bus_low_drive_en
);

  logic [SYNC_W-1:0] s1_q, s2_q, s3_q, clean_q, prev_q;
  logic [SYNC_W-1:0] rise, edge_any;
  logic              core_rst;
  bsw_wd_state_type  wd_q;
  logic [TICK_W-1:0] wd_cnt_q;
  logic [DIV_W-1:0]  div_q;
  logic              tick;
  logic              sync_seen_q;
  logic              wd_caused_q;
  logic              shutdown_q;
  logic              sleep_q;
  logic [7:0]        dead_time_q;
  logic [7:0]        dead_cnt_q;
  logic [7:0]        rst_count_q;
  logic              wd_fail;
  logic              strap_done_q;
  logic [3:0]        short_q;
  logic              bridge_en;
  logic [3:0]        want;
  logic [3:0]        gate_d;
  logic [3:0]        gate_q;
  logic              acc_q;
  logic [31:0]       rd_mux;

  // Three-stage pin synchroniser; value moves once stages 2 and 3 agree
  always_ff @(posedge clock) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= {short_detect, supply_level_select, int_power_good,
               vcc_power_good, bus_overheat, heat_recovered,
               heat_cutoff, heat_warning, pump_good, supply_not_high,
               supply_too_low, tx_in, pwm_in, dir_in,
               watchdog_kick_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_clean
      always_ff @(posedge clock) begin
        if (rst) begin
          clean_q[gi] <= 1'b0;
          prev_q[gi]  <= 1'b0;
        end else begin
          if (s2_q[gi] == s3_q[gi]) clean_q[gi] <= s3_q[gi];
          prev_q[gi] <= clean_q[gi];
        end
      end
      assign rise[gi]     = clean_q[gi] & ~prev_q[gi];
      assign edge_any[gi] = clean_q[gi] ^ prev_q[gi];
    end
  endgenerate

  // Whole core stays reset while the internal supply is low
  assign core_rst = rst | ~clean_q[IN_INTPG];

  // Strap captured once after reset; later changes are ignored
  always_ff @(posedge clock) begin
    if (core_rst) begin
      strap_done_q  <= 1'b0;
      level_3v3_out <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q  <= 1'b1;
      level_3v3_out <= ~clean_q[IN_LEVEL];
    end
  end

  // Oscillator tick divider; frozen in sleep to save activity
  always_ff @(posedge clock) begin
    if (core_rst) begin
      div_q <= '0;
    end else if (!sleep_q) begin
      if (div_q == DIV_W'(TICK_CYCLES - 1)) div_q <= '0;
      else div_q <= div_q + 1'b1;
    end
  end
  assign tick = (div_q == DIV_W'(TICK_CYCLES - 1)) && !sleep_q;

  // Latched thermal shutdown; released only when cooled below recovery
  always_ff @(posedge clock) begin
    if (core_rst) begin
      shutdown_q <= 1'b0;
    end else if (clean_q[IN_CUT]) begin
      shutdown_q <= 1'b1;
    end else if (clean_q[IN_COOL]) begin
      shutdown_q <= 1'b0;
    end
  end

  // Window watchdog sequencer
  always_ff @(posedge clock) begin
    if (core_rst) begin
      wd_q        <= WD_RESET;
      wd_cnt_q    <= TICK_W'(RES_TICKS);
      sync_seen_q <= 1'b0;
      wd_caused_q <= 1'b0;
      wd_fail     <= 1'b0;
    end else if (!clean_q[IN_VCCPG] || shutdown_q) begin
      // Supply low or overheated: start over from power-on hold
      wd_q        <= WD_RESET;
      wd_cnt_q    <= TICK_W'(RES_TICKS);
      sync_seen_q <= 1'b0;
      wd_caused_q <= 1'b0;
      wd_fail     <= 1'b0;
    end else if (sleep_q) begin
      wd_fail <= 1'b0;
    end else begin
      wd_fail <= 1'b0;
      unique case (wd_q)
        WD_RESET: begin
          if (tick) begin
            if (wd_cnt_q <= TICK_W'(1)) begin
              wd_q        <= WD_LEAD;
              wd_cnt_q    <= TICK_W'(LEAD_TICKS);
              wd_caused_q <= 1'b0;
            end else begin
              wd_cnt_q <= wd_cnt_q - 1'b1;
            end
          end
        end
        WD_LEAD: begin
          if (rise[IN_KICK]) begin
            wd_q        <= WD_CLOSED;
            wd_cnt_q    <= TICK_W'(CLOSE_TICKS);
            sync_seen_q <= 1'b1;
          end else if (tick) begin
            if (wd_cnt_q <= TICK_W'(1)) begin
              wd_q        <= WD_RESET;
              wd_cnt_q    <= TICK_W'(RES_TICKS);
              wd_caused_q <= 1'b1;
              wd_fail     <= 1'b1;
            end else begin
              wd_cnt_q <= wd_cnt_q - 1'b1;
            end
          end
        end
        WD_CLOSED: begin
          if (rise[IN_KICK]) begin
            // Early kick counts as a failed trigger
            wd_q        <= WD_RESET;
            wd_cnt_q    <= TICK_W'(SHORT_RES_TICKS);
            sync_seen_q <= 1'b0;
            wd_caused_q <= 1'b1;
            wd_fail     <= 1'b1;
          end else if (tick) begin
            if (wd_cnt_q <= TICK_W'(1)) begin
              wd_q     <= WD_OPEN;
              wd_cnt_q <= TICK_W'(OPEN_TICKS);
            end else begin
              wd_cnt_q <= wd_cnt_q - 1'b1;
            end
          end
        end
        WD_OPEN: begin
          if (rise[IN_KICK]) begin
            wd_q     <= WD_CLOSED;
            wd_cnt_q <= TICK_W'(CLOSE_TICKS);
          end else if (tick) begin
            if (wd_cnt_q <= TICK_W'(1)) begin
              wd_q        <= WD_RESET;
              wd_cnt_q    <= TICK_W'(SHORT_RES_TICKS);
              sync_seen_q <= 1'b0;
              wd_caused_q <= 1'b1;
              wd_fail     <= 1'b1;
            end else begin
              wd_cnt_q <= wd_cnt_q - 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Supply-side pins
  always_ff @(posedge clock) begin
    if (core_rst) begin
      host_reset_n    <= 1'b0;
      regulator_en    <= 1'b0;
      battery_tap_out <= 1'b0;
    end else begin
      host_reset_n    <= (wd_q != WD_RESET) && !shutdown_q;
      regulator_en    <= !shutdown_q;
      battery_tap_out <= clean_q[IN_VCCPG] | wd_caused_q;
    end
  end

  // Bridge enable from trigger, supply, pump and temperature
  assign bridge_en = sync_seen_q & ~clean_q[IN_LOW]
                   & clean_q[IN_NOTHIGH] & clean_q[IN_PUMP]
                   & ~shutdown_q;

  // Gate pattern: one high side stays on, other leg's high and low sides chop
  always_comb begin
    if (!clean_q[IN_DIR]) begin
      want = {1'b1, 1'b0, ~clean_q[IN_PWM], clean_q[IN_PWM]};
    end else begin
      want = {~clean_q[IN_PWM], clean_q[IN_PWM], 1'b1, 1'b0};
    end
  end

  // Non-overlap timer restarts on any PWM or direction change
  always_ff @(posedge clock) begin
    if (core_rst) begin
      dead_cnt_q <= '0;
    end else if (edge_any[IN_PWM] || edge_any[IN_DIR]) begin
      dead_cnt_q <= dead_time_q;
    end else if (dead_cnt_q != 8'h00) begin
      dead_cnt_q <= dead_cnt_q - 1'b1;
    end
  end

  // While the timer runs a gate may turn off but never on
  always_comb begin
    gate_d = want & {4{bridge_en}} & ~short_q;
    if (dead_cnt_q != 8'h00 || edge_any[IN_PWM] || edge_any[IN_DIR]) begin
      gate_d = gate_d & gate_q;
    end
  end

  always_ff @(posedge clock) begin
    if (core_rst) gate_q <= '0;
    else gate_q <= gate_d;
  end
  assign gates = gate_q;

  // Per-transistor short debounce and latch
  generate
    for (gi = 0; gi < 4; gi++) begin : g_short
      logic [SC_W-1:0] sc_cnt_q;
      logic            sc_hit;
      assign sc_hit = gate_q[gi] & clean_q[IN_SHORT + gi]
                    & (sc_cnt_q == SC_W'(SC_CYCLES - 1));
      always_ff @(posedge clock) begin
        if (core_rst) begin
          sc_cnt_q <= '0;
        end else if (gate_q[gi] && clean_q[IN_SHORT + gi]) begin
          if (!sc_hit) sc_cnt_q <= sc_cnt_q + 1'b1;
        end else begin
          sc_cnt_q <= '0;
        end
      end
      // New detection wins over a clearing PWM edge
      always_ff @(posedge clock) begin
        if (core_rst) short_q[gi] <= 1'b0;
        else if (sc_hit) short_q[gi] <= 1'b1;
        else if (edge_any[IN_PWM]) short_q[gi] <= 1'b0;
      end
    end
  endgenerate

  // Diagnostic pins
  always_ff @(posedge clock) begin
    if (core_rst) begin
      diag <= '0;
    end else begin
      diag.short_fault_out  <= |short_q;
      diag.supply_fault_out <= ~clean_q[IN_PUMP] | clean_q[IN_LOW]
                             | ~clean_q[IN_NOTHIGH];
      diag.heat_warning_out <= clean_q[IN_WARN];
    end
  end

  // Bus transmit path; recessive high in shutdown
  always_ff @(posedge clock) begin
    if (core_rst) begin
      bus_tx_out       <= 1'b1;
      bus_low_drive_en <= 1'b0;
    end else begin
      bus_tx_out       <= clean_q[IN_TX] | shutdown_q;
      bus_low_drive_en <= !shutdown_q
                        && !clean_q[IN_BUSHOT];
    end
  end

  // Register read view
  always_comb begin
    rd_mux = '0;
    unique case (avs_address)
      OFS_CTRL:   rd_mux = {16'h0000, dead_time_q, 7'h00, sleep_q};
      OFS_STATUS: rd_mux = {12'h000, short_q, wd_q, 4'h0, gate_q,
                            level_3v3_out, shutdown_q, bridge_en,
                            sync_seen_q};
      OFS_RSTCNT: rd_mux = {24'h000000, rst_count_q};
      default:    rd_mux = '0;
    endcase
  end

  // Slave answers one cycle after a request is seen
  always_ff @(posedge clock) begin
    if (core_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
      acc_q           <= 1'b0;
    end else if ((avs_read || avs_write) && !acc_q) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= avs_read ? rd_mux : 32'h00000000;
      acc_q           <= 1'b1;
    end else begin
      avs_waitrequest <= 1'b1;
      acc_q           <= 1'b0;
    end
  end

  // Control register write at the accepting edge
  always_ff @(posedge clock) begin
    if (core_rst) begin
      sleep_q     <= 1'b0;
      dead_time_q <= DEAD_CYCLES_RST;
    end else if (avs_write && acc_q && avs_address == OFS_CTRL) begin
      if (avs_byteenable[0]) sleep_q <= avs_writedata[CTRL_SLEEP_BIT];
      if (avs_byteenable[1]) begin
        dead_time_q <= avs_writedata[CTRL_DEAD_LSB +: 8];
      end
    end
  end

  // Watchdog reset counter; a failure with a clearing write leaves it at 1
  always_ff @(posedge clock) begin
    if (core_rst) begin
      rst_count_q <= '0;
    end else if (wd_fail) begin
      if (avs_write && acc_q && avs_address == OFS_RSTCNT) begin
        rst_count_q <= 8'h01;
      end else if (rst_count_q != 8'hFF) begin
        rst_count_q <= rst_count_q + 1'b1;
      end
    end else if (avs_write && acc_q && avs_address == OFS_RSTCNT) begin
      rst_count_q <= '0;
    end
  end

endmodule // bsw_core

/* testbench/bsw_core_properties.sv */
`timescale 1ns/1ns
module bsw_core_properties
  import bsw_pkg::*;
(
  input wire logic         clock,
  input wire logic         rst,
  input wire logic         avs_read,
  input wire logic         avs_write,
  input wire logic         avs_waitrequest,
  input wire logic         vcc_power_good,
  input wire logic         int_power_good,
  input wire logic         pump_good,
  input wire logic         supply_too_low,
  input wire logic         heat_warning,
  input wire logic         heat_cutoff,
  input wire logic         bus_overheat,
  input wire logic         host_reset_n,
  input wire logic         regulator_en,
  input wire logic         battery_tap_out,
  input wire bsw_gate_type gates,
  input wire bsw_diag_type diag,
  input wire logic         bus_low_drive_en
);
  // Eight-cycle holds cover the three-stage input sync plus output flops
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);

  a_wait_answer: assert property (
    $rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("bus answer late");
  a_wait_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer held");
  a_int_reset: assert property (
    !int_power_good [*8] |-> !host_reset_n && gates == '0 && diag == '0)
    else $error("outputs live in core reset");
  a_tap_on: assert property (
    (vcc_power_good && int_power_good) [*8] |-> battery_tap_out)
    else $error("tap off with supply up");
  a_low_gates: assert property (
    supply_too_low [*8] |-> gates == '0)
    else $error("gates on with battery alarm");
  a_warn_flag: assert property (
    heat_warning [*8] |-> diag.heat_warning_out)
    else $error("heat warning not flagged");
  a_cutoff_all: assert property (
    heat_cutoff [*8] |-> !host_reset_n && !regulator_en
    && gates == '0 && !bus_low_drive_en)
    else $error("cutoff left something on");
  a_bus_heat: assert property (
    bus_overheat [*8] |-> !bus_low_drive_en)
    else $error("bus driver on while hot");
  a_vcc_reset: assert property (
    !vcc_power_good [*8] |-> !host_reset_n)
    else $error("host not reset on low supply");
  a_pump_flag: assert property (
    !pump_good [*8] |-> diag.supply_fault_out)
    else $error("pump failure not flagged");
  a_leg_a_gap: assert property (
    $fell(gates.high_a) |-> !gates.low_a [*8])
    else $error("leg a overlap");
  a_leg_b_gap: assert property (
    $fell(gates.high_b) |-> !gates.low_b [*8])
    else $error("leg b overlap");

  c_host_up: cover property ($rose(host_reset_n));
  c_low_b_on: cover property ($rose(gates.low_b));
  c_read_done: cover property (avs_read && !avs_waitrequest);
endmodule // bsw_core_properties

bind bsw_core bsw_core_properties chk_i (.*);

/* testbench/bsw_host_model.sv */
`timescale 1ns/1ns
module bsw_host_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        host_reset_n,
  input  wire logic        kick_en,
  input  wire logic [15:0] kick_gap,
  output logic             watchdog_kick_in
);
  logic [15:0] wait_q;
  // Host in reset is silent; else one kick per gap, held seven cycles
  always_ff @(posedge clock) begin
    if (rst || !host_reset_n) begin
      wait_q           <= 16'h0000;
      watchdog_kick_in <= 1'b0;
    end else begin
      wait_q <= (wait_q >= kick_gap) ? 16'h0000 : wait_q + 16'h0001;
      if (wait_q >= kick_gap && kick_en) begin
        watchdog_kick_in <= 1'b1;
      end else if (wait_q == 16'h0006) begin
        watchdog_kick_in <= 1'b0;
      end
    end
  end
endmodule // bsw_host_model

/* testbench/bridge_supervisor_watchdog_bench.sv */
`timescale 1ns/1ns
module bridge_supervisor_watchdog_bench;
  import bsw_pkg::*;
  logic clock = 1'b0, rst = 1'b1, kick_en = 1'b1, watchdog_kick_in;
  logic [15:0] kick_gap = 16'h0038;
  logic dir_in = 1'b0, pwm_in = 1'b0, tx_in = 1'b1, supply_too_low = 1'b0;
  logic supply_not_high = 1'b1, pump_good = 1'b1, heat_warning = 1'b0;
  logic heat_cutoff = 1'b0, heat_recovered = 1'b1, bus_overheat = 1'b0;
  logic vcc_power_good = 1'b1, int_power_good = 1'b1;
  logic supply_level_select = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0] short_detect = 4'h0, avs_address = 4'h0, avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic avs_waitrequest, host_reset_n, regulator_en, battery_tap_out;
  logic level_3v3_out, bus_tx_out, bus_low_drive_en;
  bsw_gate_type gates;
  bsw_diag_type diag;
  int err_count = 0, samples_checked = 0;

  bsw_core #(.TICK_CYCLES(4), .CLOSE_TICKS(10), .OPEN_TICKS(8),
    .RES_TICKS(12), .LEAD_TICKS(20), .SHORT_RES_TICKS(3)) dut (.*);
  bsw_host_model host (.*);

  always #10 clock = ~clock;

  task automatic chk(input string nm, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Request held until waitrequest is sampled low; one idle edge after
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int t;
    t = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= ~wr;
    avs_write     <= wr;
    do begin
      @(posedge clock);
      t++;
    end while (avs_waitrequest !== 1'b0 && t < 40);
    q = avs_readdata;
    if (t >= 40) err_count++;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wait_rst(input logic lvl, output int n);
    n = 0;
    while (host_reset_n !== lvl && n < 400) begin
      @(posedge clock);
      n++;
    end
    if (n >= 400) err_count++;
  endtask
  function automatic logic [31:0] gate_exp(input logic d, p);
    return d ? {28'h0, ~p, p, 2'b10} : {28'h0, 2'b10, ~p, p};
  endfunction
  function automatic logic [31:0] in_rng(input int n, lo, hi);
    return 32'(n >= lo && n <= hi);
  endfunction
  task automatic tally_and_finish;
    if (err_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Run budget well above the expected few thousand cycles
  initial begin
    repeat (30000) @(posedge clock);
    err_count++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] q;
    int n;
    q = $urandom(14704);
    cyc(20);
    rst <= 1'b0;
    wait_rst(1'b1, n);
    chk("hold", 1, in_rng(n, 40, 56));
    bus(0, 4'h0, 0, q);
    chk("ctrl", 32'h4400, q);
    bus(1, 4'hC, 32'hFFFF_FFFF, q);
    bus(0, 4'hC, 0, q);
    chk("unmapped", 0, q);
    chk("level", 1, 32'(level_3v3_out));
    cyc(80);
    bus(0, 4'h4, 0, q);
    chk("enable", 3, q[1:0]);
    // Random direction and duty; kicks keep landing in the open window
    repeat (8) begin
      dir_in <= 1'($urandom_range(1));
      pwm_in <= 1'($urandom_range(1));
      cyc(90);
      chk("gates", gate_exp(dir_in, pwm_in), 32'(gates));
      chk("no reset", 1, 32'(host_reset_n));
    end
    // Dead time lane only; masked sleep lane must stay clear
    avs_byteenable <= 4'h2;
    bus(1, 4'h0, 32'h1001, q);
    avs_byteenable <= 4'hF;
    bus(0, 4'h0, 0, q);
    chk("lanes", 32'h1000, q);
    dir_in <= 1'b0;
    pwm_in <= 1'b0;
    cyc(90);
    pwm_in <= 1'b1;
    cyc(12);
    // Only gates on in both patterns may stand during the gap
    chk("dead", gate_exp(0, 0) & gate_exp(0, 1), 32'(gates));
    cyc(18);
    chk("after dead", gate_exp(0, 1), 32'(gates));
    for (int k = 0; k < 3; k++) begin
      {pump_good, supply_not_high, supply_too_low} <= 3'b110 ^ (3'b1 << k);
      cyc(10);
      chk("fault gates", 0, 32'(gates));
      chk("supply flag", 1, 32'(diag.supply_fault_out));
      {pump_good, supply_not_high, supply_too_low} <= 3'b110;
      cyc(90);
    end
    heat_warning <= 1'b1;
    cyc(10);
    chk("warn", 1, 32'(diag.heat_warning_out));
    chk("warn gates", gate_exp(0, 1), 32'(gates));
    heat_warning <= 1'b0;
    pwm_in <= 1'b0;
    cyc(90);
    short_detect <= 4'h8;
    cyc(520);
    chk("short gate", 32'h2, 32'(gates));
    chk("short flag", 1, 32'(diag.short_fault_out));
    short_detect <= 4'h0;
    pwm_in <= 1'b1;
    cyc(90);
    chk("short clear", gate_exp(0, 1), 32'(gates));
    chk("flag clear", 0, 32'(diag.short_fault_out));
    repeat (4) begin
      tx_in <= 1'($urandom_range(1));
      cyc(8);
      chk("tx", 32'(tx_in), 32'(bus_tx_out));
    end
    bus_overheat <= 1'b1;
    cyc(10);
    chk("bus hot", 0, 32'(bus_low_drive_en));
    chk("bus hot gates", gate_exp(0, 1), 32'(gates));
    bus_overheat <= 1'b0;
    // Early kick inside the closed window
    @(posedge watchdog_kick_in);
    kick_gap <= 16'h000A;
    wait_rst(1'b0, n);
    kick_gap <= 16'h0038;
    chk("tap", 1, 32'(battery_tap_out));
    wait_rst(1'b1, n);
    chk("short hold", 1, in_rng(n, 8, 16));
    cyc(150);
    chk("restart", 1, 32'(host_reset_n));
    bus(0, 4'h8, 0, q);
    chk("fails", 1, q);
    bus(1, 4'h8, 0, q);
    bus(0, 4'h8, 0, q);
    chk("fails clr", 0, q);
    kick_en <= 1'b0;
    wait_rst(1'b0, n);
    wait_rst(1'b1, n);
    wait_rst(1'b0, n);
    chk("lead", 1, in_rng(n, 72, 88));
    wait_rst(1'b1, n);
    chk("lead hold", 1, in_rng(n, 40, 56));
    bus(1, 4'h0, 32'h1001, q);
    cyc(300);
    chk("sleep", 1, 32'(host_reset_n));
    bus(1, 4'h0, 32'h1000, q);
    kick_en <= 1'b1;
    heat_cutoff <= 1'b1;
    heat_recovered <= 1'b0;
    cyc(10);
    chk("cut", 0, 32'({host_reset_n, regulator_en, gates}));
    heat_cutoff <= 1'b0;
    cyc(100);
    chk("hot hold", 0, 32'(host_reset_n));
    heat_recovered <= 1'b1;
    wait_rst(1'b1, n);
    chk("cooled", 1, in_rng(n, 40, 80));
    vcc_power_good <= 1'b0;
    cyc(10);
    chk("vcc", 0, 32'(host_reset_n));
    chk("tap off", 0, 32'(battery_tap_out));
    // Strap moves only while the whole chip is held in reset
    vcc_power_good <= 1'b1;
    int_power_good <= 1'b0;
    supply_level_select <= 1'b1;
    cyc(10);
    chk("int pg", 0, 32'({host_reset_n, gates}));
    int_power_good <= 1'b1;
    cyc(10);
    chk("level 5v", 0, 32'(level_3v3_out));
    tally_and_finish();
  end
endmodule // bridge_supervisor_watchdog_bench
